// [hw/bsctap_consts.svh]
// Purpose: Constants for the boundary-scan test access port
// Assumes: Included by bare name from the package and design files
// Notes:   Offsets, field positions, reset values and codes only
//
// Summary of operation
// - Three-bit instruction register, shifted in least significant bit first, selects path.
// - Code 000: boundary chain in path, pins captured, outputs from updated latch.
// - Code 100: boundary chain in path, normal pin paths kept, all values captured.
// - Code 110: identification register placed between test data in and out.
// - Code 111: data passes through one test clock period of delay.
// - Identification register is 32 bits, shifted out least significant bit first.
// - Identification: bit 0 one, producer 1-11, part 12-27, revision 28-31.
// - Bypass stage is one flip-flop forming a one-bit serial path.
// - Boundary chain is 98 bits, used only under external test or sample.
// - Controller is a synchronous 16-state machine with data and instruction branches.
// - Reset state disables test logic and loads the identification instruction.
// - Mode select high for five rising edges reaches reset; stays while high.
// - Controller enters reset state at power-up without any sequence.
// - Idle holds while mode select low; high moves to data select.
// - Data select goes to data capture on low, instruction select on high.
// - Instruction capture loads fixed pattern 100 on the rising edge.
// - Data shift advances selected register one stage per rising edge.
// - Boundary parallel latch loads on falling edge in data update only.
`ifndef BSCTAP_CONSTS_SVH
`define BSCTAP_CONSTS_SVH

`define BSCTAP_IR_W        3
`define BSCTAP_IR_EXTEST   3'h0
`define BSCTAP_IR_SAMPLE   3'h4
`define BSCTAP_IR_IDCODE   3'h6
`define BSCTAP_IR_BYPASS   3'h7
`define BSCTAP_IR_CAPTURE  3'h4
`define BSCTAP_ID_W        32
`define BSCTAP_BSR_W       98
`define BSCTAP_ID_ONE_BIT  0
`define BSCTAP_ID_PROD_LSB 1
`define BSCTAP_ID_PART_LSB 12
`define BSCTAP_ID_REV_LSB  28
`define BSCTAP_RST_EDGES   5

`endif

// [hw/bsctap_pkg.sv]
// Purpose: Types for the boundary-scan test access port
// Assumes: Header of constants is available on the include path
// Notes:   One-hot controller state codes
`include "bsctap_consts.svh"
package bsctap_pkg;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE  = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SHDR  = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PSDR  = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PSIR  = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } bsctap_state_e;

  typedef struct packed {
    logic tms;
    logic tdi;
  } bsctap_scan_in_s;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bsctap_scan_out_s;

endpackage : bsctap_pkg

// [hw/bsctap_fsm.sv]
// Purpose: Sixteen-state test access port controller
// Assumes: Runs on the test clock, async active-low reset
// Notes:   Next state decoded combinationally from mode select
`timescale 1ns/10ps
`default_nettype none
module bsctap_fsm
  import bsctap_pkg::*;
(
  // Test clock and reset
  input  wire logic          tck_i,
  input  wire logic          trst_n_i,
  // Mode select
  input  wire logic          tms_i,
  // State
  output bsctap_state_e      state_o
);

  bsctap_state_e state_q;
  bsctap_state_e state_d;

  // Standard state graph
  always_comb begin
    case (state_q)
      ST_RESET: state_d = tms_i ? ST_RESET : ST_IDLE;
      ST_IDLE:  state_d = tms_i ? ST_SELDR : ST_IDLE;
      ST_SELDR: state_d = tms_i ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: state_d = tms_i ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  state_d = tms_i ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: state_d = tms_i ? ST_UPDR  : ST_PSDR;
      ST_PSDR:  state_d = tms_i ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: state_d = tms_i ? ST_UPDR  : ST_SHDR;
      ST_UPDR:  state_d = tms_i ? ST_SELDR : ST_IDLE;
      ST_SELIR: state_d = tms_i ? ST_RESET : ST_CAPIR;
      ST_CAPIR: state_d = tms_i ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  state_d = tms_i ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: state_d = tms_i ? ST_UPIR  : ST_PSIR;
      ST_PSIR:  state_d = tms_i ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: state_d = tms_i ? ST_UPIR  : ST_SHIR;
      ST_UPIR:  state_d = tms_i ? ST_SELDR : ST_IDLE;
      default:  state_d = ST_RESET;
    endcase
  end

  // Power-up lands in reset state
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o = state_q;

  // Five high edges always reach reset
  a_tms_reset: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tms_i [*5] |=> (state_q == ST_RESET))
    else $error("five tms high edges did not reach reset");

  a_idle_hold: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (state_q == ST_IDLE) |=> (state_q == ($past(tms_i) ? ST_SELDR : ST_IDLE)))
    else $error("idle transition wrong");

  a_seldr_next: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    (state_q == ST_SELDR) |=> (state_q == ($past(tms_i) ? ST_SELIR : ST_CAPDR)))
    else $error("data select transition wrong");

endmodule : bsctap_fsm
`default_nettype wire

// [hw/bsctap_top.sv]
// Purpose: Boundary-scan test access port with instruction and data registers
// Assumes: Test clock is its own domain; core pins cross on core_clk_i
// Notes:   Test data out registered on falling test clock edge
`timescale 1ns/10ps
`default_nettype none
`include "bsctap_consts.svh"
module bsctap_top
  import bsctap_pkg::*;
#(
  parameter int          BSR_W    = `BSCTAP_BSR_W,
  parameter logic [10:0] PRODUCER = 11'h07F,   // Arbitrary value
  parameter logic [15:0] PART     = 16'h1234,  // Arbitrary value
  parameter logic [3:0]  REVISION = 4'h1       // Arbitrary value
) (
  // Core clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Scan link
  input  wire logic             tck_i,
  input  wire bsctap_scan_in_s  scan_i,
  output bsctap_scan_out_s      scan_o,
  // Core side pins
  input  wire logic [BSR_W-1:0] core_pin_i,
  output logic [BSR_W-1:0]      pin_drive_o,
  output logic                  test_mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Controller
  bsctap_state_e state;

  bsctap_fsm u_fsm (
    .tck_i    (tck_i),
    .trst_n_i (rst_n_i),
    .tms_i    (scan_i.tms),
    .state_o  (state)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core values into test clock domain
  logic [BSR_W-1:0] pin_sync1_q;
  logic [BSR_W-1:0] pin_sync2_q;

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sync1_q <= '0;
      pin_sync2_q <= '0;
    end else begin
      pin_sync1_q <= core_pin_i;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  logic [`BSCTAP_IR_W-1:0] ir_shift_q;
  logic [`BSCTAP_IR_W-1:0] ir_q;

  wire in_reset  = (state == ST_RESET);
  wire in_cap_ir = (state == ST_CAPIR);
  wire in_sh_ir  = (state == ST_SHIR);
  wire in_cap_dr = (state == ST_CAPDR);
  wire in_sh_dr  = (state == ST_SHDR);
  wire in_up_dr  = (state == ST_UPDR);
  wire in_up_ir  = (state == ST_UPIR);

  // Shift in least significant bit first
  wire [`BSCTAP_IR_W-1:0] ir_shift_d =
    in_cap_ir ? `BSCTAP_IR_CAPTURE :
    in_sh_ir  ? {scan_i.tdi, ir_shift_q[`BSCTAP_IR_W-1:1]} :
                ir_shift_q;

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_shift_q <= `BSCTAP_IR_IDCODE;
    end else begin
      ir_shift_q <= ir_shift_d;
    end
  end

  // Current instruction changes on falling edge of update
  always_ff @(negedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_q <= `BSCTAP_IR_IDCODE;
    end else if (in_reset) begin
      ir_q <= `BSCTAP_IR_IDCODE;
    end else if (in_up_ir) begin
      ir_q <= ir_shift_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  wire sel_extest = (ir_q == `BSCTAP_IR_EXTEST);
  wire sel_sample = (ir_q == `BSCTAP_IR_SAMPLE);
  wire sel_bsr    = sel_extest | sel_sample;
  wire sel_id     = (ir_q == `BSCTAP_IR_IDCODE);
  wire sel_byp    = !sel_bsr && !sel_id;

  ////////////////////////////////////////////////////////////////////////////
  // Identification chain
  localparam logic [`BSCTAP_ID_W-1:0] ID_VALUE =
    {REVISION, PART, PRODUCER, 1'b1};

  logic [`BSCTAP_ID_W-1:0] identification_chain_q;

  wire [`BSCTAP_ID_W-1:0] id_d =
    (in_cap_dr && sel_id) ? ID_VALUE :
    (in_sh_dr && sel_id)  ? {scan_i.tdi, identification_chain_q[`BSCTAP_ID_W-1:1]} :
                            identification_chain_q;

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      identification_chain_q <= '0;
    end else begin
      identification_chain_q <= id_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bypass stage
  logic bypass_stage_q;

  wire byp_d = (in_cap_dr && sel_byp) ? 1'b0 :
               (in_sh_dr && sel_byp)  ? scan_i.tdi : bypass_stage_q;

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bypass_stage_q <= 1'b0;
    end else begin
      bypass_stage_q <= byp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary scan chain and parallel latch
  logic [BSR_W-1:0] boundary_scan_chain_q;
  logic [BSR_W-1:0] bsr_latch_q;
  logic             upd_tgl_q;

  // Capture pins under either boundary instruction
  wire [BSR_W-1:0] bsr_d =
    (in_cap_dr && sel_bsr) ? pin_sync2_q :
    (in_sh_dr && sel_bsr)  ? {scan_i.tdi, boundary_scan_chain_q[BSR_W-1:1]} :
                             boundary_scan_chain_q;

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boundary_scan_chain_q <= '0;
    end else begin
      boundary_scan_chain_q <= bsr_d;
    end
  end

  always_ff @(negedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bsr_latch_q <= '0;
      upd_tgl_q   <= 1'b0;
    end else if (in_up_dr && sel_bsr) begin
      bsr_latch_q <= boundary_scan_chain_q;
      upd_tgl_q   <= !upd_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test data out, falling edge, enabled only while shifting
  wire tdo_dr = sel_bsr ? boundary_scan_chain_q[0] :
                sel_id  ? identification_chain_q[0] : bypass_stage_q;
  wire tdo_d  = in_sh_ir ? ir_shift_q[0] : tdo_dr;
  wire oe_d   = in_sh_ir || in_sh_dr;

  logic tdo_q;
  logic oe_q;

  always_ff @(negedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      oe_q  <= oe_d;
    end
  end

  assign scan_o.tdo    = tdo_q;
  assign scan_o.tdo_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin control into core clock domain
  logic ext_tck_q;

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_tck_q <= 1'b0;
    end else begin
      ext_tck_q <= sel_extest && !in_reset;
    end
  end

  logic             ext_s1_q;
  logic             ext_s2_q;
  logic             tgl_s1_q;
  logic             tgl_s2_q;
  logic             tgl_s3_q;
  logic [BSR_W-1:0] drv_q;

  // Latch word taken once its update toggle has settled; updates need 4 core cycles apart
  wire drv_load = tgl_s2_q ^ tgl_s3_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_s1_q    <= 1'b0;
      ext_s2_q    <= 1'b0;
      tgl_s1_q    <= 1'b0;
      tgl_s2_q    <= 1'b0;
      tgl_s3_q    <= 1'b0;
      drv_q       <= '0;
      pin_drive_o <= '0;
      test_mode_o <= 1'b0;
    end else begin
      ext_s1_q    <= ext_tck_q;
      ext_s2_q    <= ext_s1_q;
      tgl_s1_q    <= upd_tgl_q;
      tgl_s2_q    <= tgl_s1_q;
      tgl_s3_q    <= tgl_s2_q;
      drv_q       <= drv_load ? bsr_latch_q : drv_q;
      test_mode_o <= ext_s2_q;
      pin_drive_o <= ext_s2_q ? drv_q : core_pin_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_capir_load: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    in_cap_ir |=> (ir_shift_q == `BSCTAP_IR_CAPTURE))
    else $error("instruction capture pattern wrong");

  a_reset_idcode: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    in_reset ##1 in_reset |-> (ir_q == `BSCTAP_IR_IDCODE))
    else $error("reset state did not select identification");

  a_id_capture: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_cap_dr && sel_id) |=> (identification_chain_q == ID_VALUE))
    else $error("identification value wrong");

  a_id_shift: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_sh_dr && sel_id && $stable(ir_q)) |=>
      (identification_chain_q[`BSCTAP_ID_W-2:0] == $past(identification_chain_q[`BSCTAP_ID_W-1:1]))
      && (identification_chain_q[`BSCTAP_ID_W-1] == $past(scan_i.tdi)))
    else $error("identification shift wrong");

  a_bypass_delay: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_sh_dr && sel_byp) |=> (bypass_stage_q == $past(scan_i.tdi)))
    else $error("bypass delay wrong");

  a_bsr_hold: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    !sel_bsr |=> $stable(boundary_scan_chain_q))
    else $error("boundary chain moved without selection");

  a_latch_only_upd: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    !in_up_dr |=> ##0 (1'b1) ##1 (in_up_dr || $stable(bsr_latch_q) || !rst_n_i))
    else $error("parallel latch changed outside update");

  a_oe_shift: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (!in_sh_dr && !in_sh_ir) ##1 (!in_sh_dr && !in_sh_ir) |-> !oe_q)
    else $error("output enabled outside shift");

  a_ir_shift: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    in_sh_ir |=> (ir_shift_q[`BSCTAP_IR_W-1] == $past(scan_i.tdi)))
    else $error("instruction shift wrong");

  a_ir_no_shift: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    in_sh_ir |=> $stable(ir_q))
    else $error("instruction changed while shifting");

  a_ir_update: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    in_up_ir |-> (ir_q == ir_shift_q))
    else $error("instruction not taken in update");

  a_ir_advance: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    in_sh_ir |=> (ir_shift_q[`BSCTAP_IR_W-2:0] == $past(ir_shift_q[`BSCTAP_IR_W-1:1])))
    else $error("instruction stages did not advance");

  a_idle_quiet: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (state == ST_IDLE) |=> ($stable(ir_q) && $stable(identification_chain_q)
      && $stable(bypass_stage_q) && $stable(boundary_scan_chain_q)))
    else $error("registers moved in idle");

  a_seldr_quiet: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (state == ST_SELDR) |=> ($stable(ir_q) && $stable(identification_chain_q)
      && $stable(bypass_stage_q) && $stable(boundary_scan_chain_q)))
    else $error("registers moved in data select");

  a_pause_quiet: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (state == ST_PSDR || state == ST_EX1DR || state == ST_EX2DR) |=>
      ($stable(identification_chain_q) && $stable(bypass_stage_q)
      && $stable(boundary_scan_chain_q)))
    else $error("data registers moved in pause or exit");

  a_update_quiet: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    in_up_dr |=> ($stable(identification_chain_q)
      && $stable(bypass_stage_q) && $stable(boundary_scan_chain_q)))
    else $error("shift stages moved in data update");

  a_bsr_capture: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_cap_dr && sel_bsr) |=> (boundary_scan_chain_q == $past(pin_sync2_q)))
    else $error("boundary capture wrong");

  a_bsr_advance: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_sh_dr && sel_bsr) |=>
      (boundary_scan_chain_q == {$past(scan_i.tdi), $past(boundary_scan_chain_q[BSR_W-1:1])}))
    else $error("boundary shift wrong");

  a_id_idle: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    !sel_id |=> $stable(identification_chain_q))
    else $error("identification moved without selection");

  a_byp_idle: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    !sel_byp |=> $stable(bypass_stage_q))
    else $error("bypass moved without selection");

  a_byp_capture: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_cap_dr && sel_byp) |=> !bypass_stage_q)
    else $error("bypass capture wrong");

  a_tdo_ir: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    in_sh_ir |-> (scan_o.tdo == ir_shift_q[0]))
    else $error("instruction bit out wrong");

  a_tdo_id: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_sh_dr && sel_id) |-> (scan_o.tdo == identification_chain_q[0]))
    else $error("identification bit out wrong");

  a_tdo_byp: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_sh_dr && sel_byp) |-> (scan_o.tdo == bypass_stage_q))
    else $error("bypass bit out wrong");

  a_tdo_bsr: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_sh_dr && sel_bsr) |-> (scan_o.tdo == boundary_scan_chain_q[0]))
    else $error("boundary bit out wrong");

  a_oe_on: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_sh_dr || in_sh_ir) |-> scan_o.tdo_oe)
    else $error("output not enabled while shifting");

  a_reset_stay: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    (in_reset && scan_i.tms) |=> in_reset)
    else $error("left reset state with mode select high");

  a_core_path: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!test_mode_o && $past(rst_n_i)) |-> (pin_drive_o == $past(core_pin_i)))
    else $error("normal pin path broken");

  a_test_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    test_mode_o |-> (pin_drive_o == $past(drv_q)))
    else $error("pins not driven from latch in test");

  a_drv_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !drv_load |=> $stable(drv_q))
    else $error("core copy of latch moved without update");

endmodule : bsctap_top
`default_nettype wire

// [verification/bsctap_tester.sv]
// Purpose: Scan controller model driving the test access port
// Assumes: Test clock runs only within frames, 6 ns period
// Notes:   Samples test data out just before each rising edge
`timescale 1ns/10ps
`default_nettype none
module bsctap_tester
  import bsctap_pkg::*;
(
  // Scan link
  output logic                  tck_o,
  output bsctap_scan_in_s       scan_o,
  input  wire bsctap_scan_out_s scan_i
);
  logic tdo_seen;
  logic oe_seen;

  initial begin
    tck_o  = 1'b0;
    scan_o = 2'b10;
  end

  ////////////////////////////////////////////////////////////////////
  // One test clock period, inputs settled well before the rise
  task automatic step(input logic tms, input logic tdi);
    scan_o.tms = tms;
    scan_o.tdi = tdi;
    #3;
    tdo_seen = scan_i.tdo;
    oe_seen  = scan_i.tdo_oe;
    tck_o    = 1'b1;
    #3;
    tck_o    = 1'b0;
  endtask : step

  // Walks the graph; unheard data in toggles every cycle
  task automatic move(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++) begin
      step(seq[i], ~scan_o.tdi);
    end
  endtask : move

  // Last bit leaves the shift state
  task automatic shift(input logic [127:0] din, input int n,
                       output logic [127:0] dout, output logic oe_all);
    dout   = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = tdo_seen;
      oe_all  = oe_all & oe_seen;
    end
  endtask : shift
endmodule : bsctap_tester
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the boundary-scan access port
// Assumes: Scan controller model drives the link
// Notes:   Pin patterns held steady across each capture
`timescale 1ns/10ps
`default_nettype none
module tb
  import bsctap_pkg::*;
;
  localparam logic [10:0] PROD   = 11'h2A5;  // Arbitrary value
  localparam logic [15:0] PART   = 16'h6C3E; // Arbitrary value
  localparam logic [3:0]  REV    = 4'hA;     // Arbitrary value
  localparam logic [31:0] ID_EXP = {REV, PART, PROD, 1'b1};
  localparam logic [97:0] PAT_A  = {2'h2, 32'hA5A5_1234, 32'h0F0F_C3C3, 32'h9669_5AA5};
  localparam logic [97:0] PAT_B  = {2'h1, 32'h1357_9BDF, 32'hF00D_0FF1, 32'h3C3C_7E81};
  localparam logic [97:0] PAT_C  = {2'h3, 32'h8421_4218, 32'h5555_AAAA, 32'h0000_FFFF};

  logic             core_clk;
  logic             rst_n;
  logic             tck;
  bsctap_scan_in_s  scan_in;
  bsctap_scan_out_s scan_out;
  logic [97:0]      core_pin;
  logic [97:0]      pin_drive;
  logic             test_mode;
  int               fails;
  int               total_checks;

  bsctap_top #(.PRODUCER(PROD), .PART(PART), .REVISION(REV)) uut (
    .core_clk_i  (core_clk),
    .rst_n_i     (rst_n),
    .tck_i       (tck),
    .scan_i      (scan_in),
    .scan_o      (scan_out),
    .core_pin_i  (core_pin),
    .pin_drive_o (pin_drive),
    .test_mode_o (test_mode)
  );

  bsctap_tester tst (
    .tck_o  (tck),
    .scan_o (scan_in),
    .scan_i (scan_out)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic set_pins(input logic [97:0] p);
    @(negedge core_clk);
    core_pin = p;
    repeat (2) @(negedge core_clk);
  endtask : set_pins

  // Idle to idle through the instruction branch
  task automatic ir_scan(input logic [2:0] code, output logic [127:0] cap);
    logic oe;
    tst.move(8'h03, 4);
    tst.shift(128'(code), 3, cap, oe);
    tst.move(8'h01, 2);
  endtask : ir_scan

  // Idle to data exit, no update yet
  task automatic dr_scan(input logic [127:0] din, input int n,
                         output logic [127:0] dout, output logic oe);
    tst.move(8'h01, 3);
    tst.shift(din, n, dout, oe);
  endtask : dr_scan

  ////////////////////////////////////////////////////////////////////
  task automatic t_idcode;
    logic [127:0] d;
    logic         oe;
    tst.move(8'h00, 4);
    check(128'(tst.oe_seen), 128'(1'b0));
    dr_scan('0, 32, d, oe);
    tst.move(8'h01, 2);
    check(d, 128'(ID_EXP));
    check(128'(oe), 128'(1'b1));
    $display("test idcode done");
  endtask : t_idcode

  // Defined bypass code, then an unassigned one
  task automatic t_bypass;
    logic [127:0] d;
    logic         oe;
    for (int k = 0; k < 2; k++) begin
      ir_scan(k == 0 ? 3'h7 : 3'h3, d);
      check(d, 128'(3'b100));
      dr_scan(128'(9'h0B5), 9, d, oe);
      tst.move(8'h01, 2);
      check(d, 128'({8'hB5, 1'b0}));
    end
    $display("test bypass done");
  endtask : t_bypass

  // Five highs from mid-shift, then a paused identification read
  task automatic t_reset5;
    logic [127:0] a;
    logic [127:0] b;
    logic         oe;
    ir_scan(3'h7, a);
    tst.move(8'h01, 3);
    tst.move(8'h1F, 6);
    dr_scan('0, 16, a, oe);
    tst.move(8'h00, 2);
    check(128'(tst.oe_seen), 128'(1'b0));
    tst.move(8'h02, 3);
    tst.shift('0, 16, b, oe);
    tst.move(8'h01, 2);
    check(128'({b[15:0], a[15:0]}), 128'(ID_EXP));
    $display("test reset5 done");
  endtask : t_reset5

  task automatic t_sample;
    logic [127:0] d;
    logic         oe;
    set_pins(PAT_A);
    ir_scan(3'h4, d);
    dr_scan(128'(PAT_B), 98, d, oe);
    check(d, 128'(PAT_A));
    tst.move(8'h01, 2);
    repeat (8) @(negedge core_clk);
    check(128'(pin_drive), 128'(PAT_A));
    check(128'(test_mode), 128'(1'b0));
    $display("test sample done");
  endtask : t_sample

  task automatic t_extest;
    logic [127:0] d;
    logic         oe;
    set_pins(PAT_C);
    ir_scan(3'h0, d);
    repeat (8) @(negedge core_clk);
    check(128'(test_mode), 128'(1'b1));
    check(128'(pin_drive), 128'(PAT_B));
    dr_scan(128'(PAT_A), 98, d, oe);
    check(d, 128'(PAT_C));
    repeat (8) @(negedge core_clk);
    check(128'(pin_drive), 128'(PAT_B));
    tst.move(8'h01, 2);
    repeat (8) @(negedge core_clk);
    check(128'(pin_drive), 128'(PAT_A));
    tst.move(8'h1F, 6);
    repeat (8) @(negedge core_clk);
    check(128'(test_mode), 128'(1'b0));
    check(128'(pin_drive), 128'(PAT_C));
    $display("test extest done");
  endtask : t_extest

  ////////////////////////////////////////////////////////////////////
  initial begin
    fails        = 0;
    total_checks = 0;
    rst_n        = 1'b0;
    core_pin     = '0;
    tst.move(8'h1F, 5);
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    t_idcode();
    t_bypass();
    t_reset5();
    t_sample();
    t_extest();
    test_done();
  end

  // Whole run needs well under 20 us
  initial begin
    #100_000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : tb
`default_nettype wire
